// *** rtl/tiopc_pkg.sv ***
package tiopc_pkg;
  // register indices on the plain port (8-bit data)
  localparam logic [3:0] ADDR_CTL_AB0 = 4'h0;
  localparam logic [3:0] ADDR_CTL_CD0 = 4'h1;
  localparam logic [3:0] ADDR_CTL_AB1 = 4'h2;
  localparam logic [3:0] ADDR_CTL_AB2 = 4'h3;
  localparam logic [3:0] ADDR_CTL_AB3 = 4'h4;
  localparam logic [3:0] ADDR_CTL_CD3 = 4'h5;
  localparam logic [3:0] ADDR_CTL_AB4 = 4'h6;
  localparam logic [3:0] ADDR_CTL_CD4 = 4'h7;
  localparam logic [3:0] ADDR_MODE    = 4'h8;
  localparam logic [3:0] ADDR_PERIOD  = 4'h9;
  localparam logic [3:0] ADDR_DEAD    = 4'hA;
  localparam logic [3:0] ADDR_STATUS  = 4'hB;
  localparam int         NUM_CTL      = 8;
  localparam logic [7:0] CTL_RESET    = 8'h00;
  // mode register fields
  localparam int MODE_BUF0 = 0;
  localparam int MODE_BUF3 = 1;
  localparam int MODE_BUF4 = 2;
  localparam int MODE_CPWM = 3;
  localparam int MODE_CLR  = 4;
  localparam int MODE_RUN  = 5;
  localparam logic [7:0] MODE_RESET   = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hFF;
  localparam logic [7:0] DEAD_RESET   = 8'h02;
  // nibble function groups
  localparam logic [1:0] GRP_OUT0 = 2'b00;
  localparam logic [1:0] GRP_OUT1 = 2'b01;
  localparam logic [1:0] GRP_CAP  = 2'b10;
  localparam logic [1:0] GRP_CNT  = 2'b11;
  // least external clock pulse, in tenths of a state
  localparam int CLK_MIN_SINGLE_X10 = 15;
  localparam int CLK_MIN_BOTH_X10   = 25;
  localparam int CLK_MIN_SINGLE_CYC = (CLK_MIN_SINGLE_X10 + 9) / 10;
  localparam int CLK_MIN_BOTH_CYC   = (CLK_MIN_BOTH_X10 + 9) / 10;
  typedef enum logic [1:0] {CNT_UP = 2'b00, CNT_DOWN = 2'b01} tiopc_dir_t;
endpackage

// *** rtl/tiopc_pin_unit.sv ***
`timescale 1ns/10ps
`default_nettype none
// one general register with its function nibble
module tiopc_pin_unit
  import tiopc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       init_req,
  input  wire logic [3:0] func_sel,
  input  wire logic       buffered,
  input  wire logic       match,
  input  wire logic       pin_in,
  input  wire logic       cnt_event,
  input  wire logic [7:0] counter,
  output logic            pin_out,
  output logic            pin_oe,
  output logic [7:0]      captured,
  output logic            capture_hit
);
  typedef struct packed {
    logic       level;
    logic       prev_in;
    logic [7:0] cap;
    logic       hit;
    logic [3:0] last_sel;
  } tiopc_pu_t;
  tiopc_pu_t st;
  tiopc_pu_t next_st;

  always_comb begin
    logic rise;
    logic fall;
    logic edge_ok;
    rise    = pin_in & ~st.prev_in;
    fall    = ~pin_in & st.prev_in;
    next_st = st;
    next_st.prev_in  = pin_in;
    next_st.hit      = 1'b0;
    next_st.last_sel = func_sel;
    edge_ok = 1'b0;
    // new setting reloads the initial level
    if (func_sel != st.last_sel || init_req) begin
      next_st.level = (func_sel[3:2] == GRP_OUT1);
    end else if (!buffered && func_sel[3] == 1'b0 && match) begin
      case (func_sel[1:0])
        2'b01:   next_st.level = 1'b0;
        2'b10:   next_st.level = 1'b1;
        2'b11:   next_st.level = ~st.level;
        default: next_st.level = st.level;
      endcase
    end
    case (func_sel[3:2])
      GRP_CAP: edge_ok = func_sel[1] ? (rise | fall) : (func_sel[0] ? fall : rise);
      GRP_CNT: edge_ok = cnt_event;
      default: edge_ok = 1'b0;
    endcase
    if (edge_ok && !buffered) begin
      next_st.cap = counter;
      next_st.hit = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pin_out     = st.level;
  assign pin_oe      = !buffered && func_sel[3] == 1'b0 && func_sel[1:0] != 2'b00;
  assign captured    = st.cap;
  assign capture_hit = st.hit;
endmodule
`default_nettype wire

// *** rtl/tiopc_cpwm.sv ***
`timescale 1ns/10ps
`default_nettype none
// three-phase complementary waveform from an up/down carrier
module tiopc_cpwm
  import tiopc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       enable,
  input  wire logic [7:0] period,
  input  wire logic [7:0] dead,
  input  wire logic [7:0] duty_1,
  input  wire logic [7:0] duty_2,
  input  wire logic [7:0] duty_3,
  input  wire logic       cut_off,
  output logic [7:0]      carrier,
  output logic [2:0]      pos,
  output logic [2:0]      neg,
  output logic            sync_tgl
);
  typedef struct packed {
    logic [7:0] cnt;
    tiopc_dir_t dir;
    logic [2:0] p;
    logic [2:0] n;
    logic       tgl;
  } tiopc_cp_t;
  tiopc_cp_t st;
  tiopc_cp_t next_st;

  function automatic logic above(input logic [7:0] c, input logic [7:0] d, input logic [7:0] off);
    logic [8:0] sum;
    sum = {1'b0, d} + {1'b0, off};
    return {1'b0, c} >= sum;
  endfunction

  always_comb begin
    logic [7:0] duty [3];
    duty[0] = duty_1;
    duty[1] = duty_2;
    duty[2] = duty_3;
    next_st = st;
    if (!enable) begin
      next_st = '0;
    end else begin
      // up/down carrier, sync toggle at each crest
      if (st.dir == CNT_UP) begin
        if (st.cnt >= period) begin
          next_st.dir = CNT_DOWN;
          next_st.cnt = st.cnt - 8'h01;
          next_st.tgl = ~st.tgl;
        end else begin
          next_st.cnt = st.cnt + 8'h01;
        end
      end else begin
        if (st.cnt == 8'h00) begin
          next_st.dir = CNT_UP;
          next_st.cnt = 8'h01;
        end else begin
          next_st.cnt = st.cnt - 8'h01;
        end
      end
      // dead band keeps each pair from overlapping
      for (int i = 0; i < 3; i++) begin
        next_st.p[i] = !cut_off && above(st.cnt, duty[i], dead);
        next_st.n[i] = !cut_off && ({1'b0, st.cnt} + {1'b0, dead} < {1'b0, duty[i]});
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign carrier  = st.cnt;
  assign pos      = st.p;
  assign neg      = st.n;
  assign sync_tgl = st.tgl;
endmodule
`default_nettype wire

// *** rtl/tiopc_top.sv ***
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - eight pin function registers: two for channels 0,3,4, one for 1,2
// - registers clear on power-on reset and standby, manual reset keeps them
// - high register: upper nibble sets register B, lower nibble register A
// - low register: upper nibble sets register D, lower nibble register C
// - buffer mode makes C/D nibble ineffective, no capture or compare
// - codes 00xx: initial level 0, then off, drive 0, drive 1, toggle
// - codes 01xx: initial level 1, then off, drive 0, drive 1, toggle
// - codes 10xx capture from pin: rising, falling, or both edges
// - channel 0 codes 11xx capture on channel 1 count events
// - complementary mode gives three non-overlapping phase pairs on channels 3,4
// - channel 3 and 4 counters count up and down in complementary mode
// - pairs: 3B/3D, 4A/4C, 4B/4D, second pin inverted and non-overlapping
// - channel 3 pin A toggles with the period or stays a port
// - external signal forces PWM outputs off through port function
// - compare-match clearing clears after final state equal to compare value
// - period is compare value plus one counts
module tiopc_top
  import tiopc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       standby,
  input  wire logic       manual_rst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  input  wire logic [7:0] general_match_a,
  input  wire logic [7:0] general_match_b,
  input  wire logic [7:0] general_match_c,
  input  wire logic [7:0] general_match_d,
  input  wire logic       chan1_count_evt,
  input  wire logic       pwm_cut_off,
  input  wire logic       chan0_pin_c_in,
  output logic            chan0_pin_c_out,
  output logic            chan0_pin_c_oe,
  output logic [7:0]      chan0_capture_c,
  output logic            chan0_capture_hit,
  output logic [7:0]      timer_counter_value,
  output logic            chan3_pin_a,
  output logic            chan3_pin_b,
  output logic            chan3_pin_d,
  output logic            chan4_pin_a,
  output logic            chan4_pin_b,
  output logic            chan4_pin_c,
  output logic            chan4_pin_d,
  output logic            pwm_oe
);
  typedef struct packed {
    logic [NUM_CTL-1:0][7:0] ctl;
    logic [7:0]              mode;
    logic [7:0]              period;
    logic [7:0]              dead;
    logic [7:0]              cnt;
    logic                    match_flag;
    logic [7:0]              rdata;
  } tiopc_top_t;
  tiopc_top_t st;
  tiopc_top_t next_st;

  logic [7:0] carrier;
  logic [2:0] pos;
  logic [2:0] neg;
  logic       sync_tgl;
  logic       c0_match;
  logic       cpwm_on;

  assign cpwm_on  = st.mode[MODE_CPWM];
  assign c0_match = st.mode[MODE_RUN] && (st.cnt == general_match_c);

  // channel 0 register C: the one general register with both capture sources
  tiopc_pin_unit u_chan0_c (
    .ref_clk     (ref_clk),
    .rst         (rst || standby),
    .init_req    (1'b0),
    .func_sel    (st.ctl[1][3:0]),
    .buffered    (st.mode[MODE_BUF0]),
    .match       (c0_match),
    .pin_in      (chan0_pin_c_in),
    .cnt_event   (chan1_count_evt),
    .counter     (st.cnt),
    .pin_out     (chan0_pin_c_out),
    .pin_oe      (chan0_pin_c_oe),
    .captured    (chan0_capture_c),
    .capture_hit (chan0_capture_hit)
  );

  tiopc_cpwm u_cpwm (
    .ref_clk  (ref_clk),
    .rst      (rst || standby),
    .enable   (cpwm_on),
    .period   (st.period),
    .dead     (st.dead),
    .duty_1   (general_match_b),
    .duty_2   (general_match_a),
    .duty_3   (general_match_d),
    .cut_off  (pwm_cut_off),
    .carrier  (carrier),
    .pos      (pos),
    .neg      (neg),
    .sync_tgl (sync_tgl)
  );

  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    next_st.match_flag = st.match_flag | c0_match;
    // free-running channel counter with compare-match clearing
    if (st.mode[MODE_RUN]) begin
      if (st.mode[MODE_CLR] && st.cnt == st.period) begin
        next_st.cnt = 8'h00;
      end else begin
        next_st.cnt = st.cnt + 8'h01;
      end
    end
    if (reg_wr) begin
      if (reg_addr < ADDR_MODE) begin
        next_st.ctl[reg_addr[2:0]] = reg_wdata;
      end else begin
        case (reg_addr)
          ADDR_MODE:   next_st.mode = reg_wdata;
          ADDR_PERIOD: next_st.period = reg_wdata;
          ADDR_DEAD:   next_st.dead = reg_wdata;
          ADDR_STATUS: next_st.match_flag = c0_match; // set wins over clear
          default:     next_st.mode = st.mode;
        endcase
      end
    end
    if (reg_rd) begin
      if (reg_addr < ADDR_MODE) begin
        next_st.rdata = st.ctl[reg_addr[2:0]];
      end else begin
        case (reg_addr)
          ADDR_MODE:   next_st.rdata = st.mode;
          ADDR_PERIOD: next_st.rdata = st.period;
          ADDR_DEAD:   next_st.rdata = st.dead;
          ADDR_STATUS: next_st.rdata = {6'h00, sync_tgl, st.match_flag};
          default:     next_st.rdata = 8'h00;
        endcase
      end
    end
  end

  // manual reset deliberately leaves the state alone, clearing only the read data
  always_ff @(posedge ref_clk) begin
    if (rst || standby) begin
      st.ctl        <= '{default: CTL_RESET};
      st.mode       <= MODE_RESET;
      st.period     <= PERIOD_RESET;
      st.dead       <= DEAD_RESET;
      st.cnt        <= 8'h00;
      st.match_flag <= 1'b0;
      st.rdata      <= 8'h00;
    end else if (!manual_rst) begin
      st <= next_st;
    end else begin
      st.rdata <= 8'h00;
    end
  end

  assign reg_rdata           = st.rdata;
  assign timer_counter_value = cpwm_on ? carrier : st.cnt;
  assign chan3_pin_a         = cpwm_on & sync_tgl;
  assign chan3_pin_b         = pos[0];
  assign chan3_pin_d         = neg[0];
  assign chan4_pin_a         = pos[1];
  assign chan4_pin_c         = neg[1];
  assign chan4_pin_b         = pos[2];
  assign chan4_pin_d         = neg[2];
  assign pwm_oe              = cpwm_on & ~pwm_cut_off;
endmodule
`default_nettype wire

// *** tb/tiopc_chk_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module tiopc_chk
  import tiopc_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       standby,
  input wire logic       manual_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       pwm_cut_off,
  input wire logic       chan0_pin_c_oe,
  input wire logic [7:0] timer_counter_value,
  input wire logic       chan3_pin_b,
  input wire logic       chan3_pin_d,
  input wire logic       chan4_pin_a,
  input wire logic       chan4_pin_b,
  input wire logic       chan4_pin_c,
  input wire logic       chan4_pin_d,
  input wire logic       pwm_oe
);
  logic [7:0] sh [16];
  // shadow of software writes, cleared like the block except index 10, which resets to 0 where the dead register resets to DEAD_RESET
  always_ff @(posedge ref_clk) begin
    if (rst || standby) begin
      for (int i = 0; i < 16; i++) sh[i] <= (i == 9) ? PERIOD_RESET : 8'h00;
    end else if (reg_wr && !manual_rst) begin
      sh[reg_addr] <= reg_wdata;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst || standby);
  sequence s_rd;
    reg_rd && !manual_rst && reg_addr < 4'h8;
  endsequence
  // settings unchanged since last cycle, so a fresh write cannot race the count
  sequence s_clr_run;
    sh[8][MODE_CLR] && sh[8][MODE_RUN] && !sh[8][MODE_CPWM] && !manual_rst && sh[8] == $past(sh[8])
      && sh[9] == $past(sh[9]);
  endsequence
  // registered pwm pins, so they fall one edge after the cut
  sequence s_pwm_quiet;
    !(chan3_pin_b || chan3_pin_d || chan4_pin_a || chan4_pin_b || chan4_pin_c || chan4_pin_d);
  endsequence
  rd_idle_zero_a: assert property ((!reg_rd || manual_rst) |=> reg_rdata == 8'h00)
    else $error("read data not zero outside answer");
  ctl_readback_a: assert property (s_rd |=> reg_rdata == $past(sh[reg_addr]))
    else $error("control register read back wrong");
  oe_off_a: assert property ((sh[1][1:0] == 2'b00 || sh[1][3] || sh[8][MODE_BUF0]) |-> !chan0_pin_c_oe)
    else $error("pin driven while output disabled");
  pwm_cut_a: assert property (pwm_cut_off |-> !pwm_oe ##1 s_pwm_quiet)
    else $error("pwm outputs enabled during cut off");
  pair_gap_a: assert property (!(chan3_pin_b && chan3_pin_d) && !(chan4_pin_a && chan4_pin_c)
    && !(chan4_pin_b && chan4_pin_d))
    else $error("phase pair overlaps");
  clr_wrap_a: assert property (s_clr_run ##0 timer_counter_value == sh[9] |=> timer_counter_value == 8'h00)
    else $error("counter not cleared after match");
  clr_step_a: assert property (s_clr_run ##0 timer_counter_value != sh[9]
    |=> timer_counter_value == 8'($past(timer_counter_value) + 8'h01))
    else $error("counter skipped a count");
  manual_hold_a: assert property (manual_rst && $past(manual_rst) |-> $stable(timer_counter_value))
    else $error("state moved during manual reset");
endmodule
bind tiopc_top tiopc_chk i_tiopc_chk (.ref_clk(ref_clk), .rst(rst), .standby(standby), .manual_rst(manual_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pwm_cut_off(pwm_cut_off), .chan0_pin_c_oe(chan0_pin_c_oe), .timer_counter_value(timer_counter_value),
  .chan3_pin_b(chan3_pin_b), .chan3_pin_d(chan3_pin_d), .chan4_pin_a(chan4_pin_a), .chan4_pin_b(chan4_pin_b),
  .chan4_pin_c(chan4_pin_c), .chan4_pin_d(chan4_pin_d), .pwm_oe(pwm_oe));
`default_nettype wire

// *** tb/tiopc_far_side.sv ***
`timescale 1ns/10ps
`default_nettype none
// external pulse source: pin edges plus channel 1 count events
module tiopc_far_side
  import tiopc_pkg::*;
#(
  parameter int HOLD = CLK_MIN_BOTH_CYC + 1
)
(
  input  wire logic       ref_clk,
  input  wire logic       start,
  input  wire logic [7:0] pulses,
  output logic            pin_in,
  output logic            cnt_evt,
  output logic            busy
);
  logic [7:0] left;
  int         cnt;
  initial begin
    pin_in = 1'b0;
    cnt_evt = 1'b0;
    left = 8'h00;
    cnt = 0;
  end
  // whole pulses only, so the pin always rests low between bursts
  always @(posedge ref_clk) begin
    cnt_evt <= 1'b0;
    if (start) begin
      left <= {pulses[6:0], 1'b0};
      cnt <= 0;
    end else if (left != 8'h00) begin
      if (cnt == HOLD - 1) begin
        pin_in <= ~pin_in;
        cnt_evt <= 1'b1;
        left <= left - 8'h01;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
  assign busy = (left != 8'h00);
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import tiopc_pkg::*;
;
  logic       ref_clk, rst, standby, manual_rst, reg_wr, reg_rd, start, rd_seen, cut, pa, sawb;
  logic       pin_in, evt, busy, pin_out, pin_oe, hit, p3a, p3b, p3d, p4a, p4b, p4c, p4d, oe;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, ga, gb, gc, gd, pulses, tcv, cap, prev, last_tcv;
  logic [7:0] q[$];
  logic [7:0] mem[8];
  logic [7:0] cc[6] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0A};
  logic [7:0] ex[6] = '{8'h03, 8'h03, 8'h06, 8'h06, 8'h06, 8'h00};
  int         fail_count, checks, hits, base, seed, n, tg;
  tiopc_top i_tiopc_top (.ref_clk(ref_clk), .rst(rst), .standby(standby), .manual_rst(manual_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .general_match_a(ga), .general_match_b(gb), .general_match_c(gc), .general_match_d(gd),
    .chan1_count_evt(evt), .pwm_cut_off(cut), .chan0_pin_c_in(pin_in), .chan0_pin_c_out(pin_out),
    .chan0_pin_c_oe(pin_oe), .chan0_capture_c(cap), .chan0_capture_hit(hit), .timer_counter_value(tcv),
    .chan3_pin_a(p3a), .chan3_pin_b(p3b), .chan3_pin_d(p3d), .chan4_pin_a(p4a), .chan4_pin_b(p4b),
    .chan4_pin_c(p4c), .chan4_pin_d(p4d), .pwm_oe(oe));
  tiopc_far_side i_tiopc_far_side (.ref_clk(ref_clk), .start(start), .pulses(pulses), .pin_in(pin_in),
    .cnt_evt(evt), .busy(busy));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic summarize();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t read %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t value %h want %h", $time, got, exp);
    end
  endtask
  // one bus cycle per call; a read notes its expected answer
  task automatic op(input logic w, r, m, input logic [3:0] a, input logic [7:0] d, e);
    @(posedge ref_clk);
    reg_wr <= w;
    reg_rd <= r;
    manual_rst <= m;
    reg_addr <= a;
    reg_wdata <= d;
    if (r) q.push_back(e);
  endtask
  task automatic idle(input int k);
    repeat (k) op(1'b0, 1'b0, 1'b0, 4'h0, 8'h00, 8'h00);
  endtask
  // one burst from the far side, then time for the last capture to land
  task automatic burst();
    start <= 1'b1;
    idle(1);
    start <= 1'b0;
    idle(1);
    for (int k = 0; k < 200 && busy !== 1'b0; k++) idle(1);
    idle(4);
  endtask
  always @(posedge ref_clk) rd_seen <= reg_rd;
  always @(negedge ref_clk) begin
    if (rd_seen === 1'b1) cmp_rd(reg_rdata, q.pop_front());
  end
  // capture takes the counter as it stood one edge before the hit shows
  always @(posedge ref_clk) begin
    last_tcv <= tcv;
    if (hit === 1'b1) begin
      hits <= hits + 1;
      cmp_val(cap, last_tcv);
    end
  end
  initial begin
    #500000;
    fail_count++;
    summarize();
  end
  initial begin
    seed = 32'h553b;
    {rst, standby, manual_rst, reg_wr, reg_rd, start, cut} = 7'h40;
    {reg_addr, reg_wdata, ga, gd, pulses, gb, gc} = {4'h0, 8'h00, 8'h00, 8'h00, 8'h03, 8'h20, 8'h80};
    {fail_count, checks, hits} = '0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    for (int a = 0; a < 16; a++) begin
      if (a != 11) op(0, 1, 0, a[3:0], 8'h00, a == 9 ? PERIOD_RESET : a == 10 ? DEAD_RESET : CTL_RESET);
    end
    for (int a = 0; a < NUM_CTL; a++) begin
      mem[a] = 8'($random(seed));
      op(1, 0, 0, a[3:0], mem[a], 8'h00);
    end
    op(1, 0, 1, ADDR_CTL_AB0, ~mem[0], 8'h00);
    op(0, 1, 1, ADDR_CTL_AB0, 8'h00, 8'h00);
    for (int a = 0; a < NUM_CTL; a++) op(0, 1, 0, a[3:0], 8'h00, mem[a]);
    idle(1);
    standby <= 1'b1;
    idle(1);
    standby <= 1'b0;
    op(0, 1, 0, ADDR_CTL_CD4, 8'h00, CTL_RESET);
    for (int c = 0; c < 8; c++) begin
      op(1, 0, 0, ADDR_CTL_CD0, 8'(c), 8'h00);
      idle(3);
      @(negedge ref_clk);
      cmp_val({7'h00, pin_out}, {7'h00, c[2]});
    end
    for (int i = 0; i < 6; i++) begin
      if (i == 5) op(1, 0, 0, ADDR_MODE, 8'(1 << MODE_BUF0), 8'h00);
      op(1, 0, 0, ADDR_CTL_CD0, cc[i], 8'h00);
      idle(2);
      base = hits;
      burst();
      cmp_val(8'(hits - base), ex[i]);
    end
    op(1, 0, 0, ADDR_PERIOD, 8'h05, 8'h00);
    op(1, 0, 0, ADDR_MODE, 8'((1 << MODE_CLR) | (1 << MODE_RUN)), 8'h00);
    for (int k = 0; k < 300 && tcv !== 8'h05; k++) @(negedge ref_clk);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (n < 300 && tcv !== 8'h05);
    cmp_val(8'(n), 8'h06);
    idle(1);
    base = hits;
    burst();
    cmp_val(8'(hits - base), 8'h06);
    gc <= 8'h03;
    op(1, 0, 0, ADDR_CTL_CD0, 8'h03, 8'h00);
    idle(3);
    @(negedge ref_clk);
    {pa, tg} = {pin_out, 32'h0};
    for (int k = 0; k < 12; k++) begin
      @(negedge ref_clk);
      if (pin_out !== pa) tg++;
      pa = pin_out;
    end
    cmp_val(8'(tg), 8'h02);
    cmp_val({7'h00, pin_oe}, 8'h01);
    op(1, 0, 0, ADDR_CTL_CD3, 8'h00, 8'h00);
    ga <= 8'($random(seed)) & 8'h3F;
    gd <= 8'($random(seed)) & 8'h3F;
    op(1, 0, 0, ADDR_PERIOD, 8'h40, 8'h00);
    op(1, 0, 0, ADDR_MODE, 8'((1 << MODE_CPWM) | (1 << MODE_RUN)), 8'h00);
    idle(3);
    {prev, pa, sawb, n, tg} = {tcv, p3a, 1'b0, 32'h0, 32'h0};
    for (int k = 0; k < 400; k++) begin
      @(negedge ref_clk);
      if (tcv < prev) n = 1;
      if (p3a !== pa) tg++;
      if (p3b === 1'b1) sawb = 1'b1;
      prev = tcv;
      pa = p3a;
    end
    cmp_val(8'(n), 8'h01);
    cmp_val(8'(tg > 0), 8'h01);
    cmp_val({7'h00, sawb}, 8'h01);
    @(posedge ref_clk);
    cut <= 1'b1;
    idle(3);
    @(negedge ref_clk);
    cmp_val({1'b0, oe, p3b, p3d, p4a, p4b, p4c, p4d}, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
